// *** logic/stcs_pkg.sv ***
package stcs_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_FORMAT   = 10'h012;
  localparam logic [9:0] IDX_CATEGORY = 10'h013;
  localparam logic [9:0] IDX_SRC_CHAN = 10'h014;
  localparam logic [9:0] IDX_RATE_ACC = 10'h015;
  localparam logic [9:0] IDX_WORD_LEN = 10'h016;
  localparam logic [9:0] IDX_POSITION = 10'h017;

  // values after reset
  localparam logic [7:0] RST_FORMAT   = 8'h00;
  localparam logic [7:0] RST_CATEGORY = 8'h00;
  localparam logic [7:0] RST_SRC_CHAN = 8'h00;
  localparam logic [7:0] RST_RATE_ACC = 8'h71;
  localparam logic [7:0] RST_WORD_LEN = 8'h0b;

  // field positions inside the rate and accuracy register
  localparam int POS_DATA_SOURCE   = 6;
  localparam int POS_STATUS_ORIGIN = 7;

  // status block geometry
  localparam int          BLOCK_FRAMES = 192;
  localparam int          CFG_BITS     = 40;
  localparam logic [7:0]  LAST_FRAME   = 8'hbf;
  localparam logic [7:0]  FIRST_FRAME  = 8'h00;

  // position register field
  localparam int POS_RELAY_FLAG = 8;

  typedef enum logic [2:0]
  {
    REG_NONE,
    REG_FORMAT,
    REG_CATEGORY,
    REG_SRC_CHAN,
    REG_RATE_ACC,
    REG_WORD_LEN,
    REG_POSITION
  } stcs_reg_type;

endpackage

// *** logic/stcs_tx_status.sv ***
`timescale 1ns/10ps

// Functional notes
// R1: status goes out as a 192-frame block, one bit in each sub-frame.
// R2: only status positions 0 to 39 are taken from the settings.
// R3: both sub-frames carry the same status; channel bits 23:20 hold channel ids.
// R4: receiver as data source relays recovered status unchanged unless origin select set.
// R5: receiver source with origin select set uses the transmit status registers.
// R6: parity bit keeps every sub-frame at even parity.
// R7: status bit 0 is format register bit 0, professional use flag, reset 0.
// R8: status bit 1 is format register bit 1, non-PCM flag, reset 0.
// R9: status bit 2 is copy unrestricted flag, reset 0.
// R10: status bits 5:3 mirror emphasis field; software keeps 000 or 001.
// R11: status bits 7:6 mirror status mode field; software keeps 00.
// R12: status bits 15:8 carry the category field, reset zero.
// R13: status bits 21:20 carry first sub-frame channel id, reset 00.
// R14: status bits 23:22 carry second sub-frame channel id, reset 00.
// R15: status bits 27:24 carry rate indication field, reset 0001.
// R16: status bits 29:28 carry clock accuracy field, reset 11.
// R17: bit 32 max length flag reset 1; bits 35:33 word length code reset 101.
// R18: bits 19:16 source id, bits 39:36 original rate; both reset zero.
// R19: bit n goes in frame n from block start; positions 40 to 191 send zero.
// R20: register changes take effect only at the next block boundary, except the source and origin selects, which act at once.
// R21: data source select resets to 1; 0 relays receiver, 1 sends audio interface.
// R22: status origin select resets to 0; matters only when relaying the receiver.
module stcs_tx_status
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        sf_req,
  input  wire logic        sf_second,
  input  wire logic        sf_block_start,
  input  wire logic [23:0] sf_audio,
  input  wire logic        sf_validity,
  input  wire logic        sf_user,
  input  wire logic        rx_status_bit,
  output logic             cs_valid,
  output logic             cs_bit,
  output logic             parity_bit,
  output logic             data_source_sel,
  output logic             status_origin_sel
);

  logic [7:0]  format_r;
  logic [7:0]  category_r;
  logic [7:0]  src_chan_r;
  logic [7:0]  rate_acc_r;
  logic [7:0]  word_len_r;
  logic [39:0] shadow_r;
  logic [7:0]  frame_r;
  logic [31:0] rdata_r;
  logic        cs_valid_r;
  logic        cs_bit_r;
  logic        parity_r;

  logic [39:0] live_vec;
  logic [39:0] cur_vec;
  logic [7:0]  cur_frame;
  logic        relay;
  logic        status_now;
  logic        wr_en;
  logic        rd_setup;
  logic [7:0]  frame_nxt;
  logic [39:0] shadow_nxt;
  logic        wr_format;
  logic        wr_category;
  logic        wr_src_chan;
  logic        wr_rate_acc;
  logic        wr_word_len;
  stcs_pkg::stcs_reg_type sel_reg;

  // byte address to register select; low two address bits must be zero
  function automatic stcs_pkg::stcs_reg_type decode(input logic [11:0] addr);
    stcs_pkg::stcs_reg_type r;
    r = stcs_pkg::REG_NONE;
    if (addr[1:0] != 2'h0)
    begin
      r = stcs_pkg::REG_NONE;
    end
    else if (addr[11:2] == stcs_pkg::IDX_FORMAT)
    begin
      r = stcs_pkg::REG_FORMAT;
    end
    else if (addr[11:2] == stcs_pkg::IDX_CATEGORY)
    begin
      r = stcs_pkg::REG_CATEGORY;
    end
    else if (addr[11:2] == stcs_pkg::IDX_SRC_CHAN)
    begin
      r = stcs_pkg::REG_SRC_CHAN;
    end
    else if (addr[11:2] == stcs_pkg::IDX_RATE_ACC)
    begin
      r = stcs_pkg::REG_RATE_ACC;
    end
    else if (addr[11:2] == stcs_pkg::IDX_WORD_LEN)
    begin
      r = stcs_pkg::REG_WORD_LEN;
    end
    else if (addr[11:2] == stcs_pkg::IDX_POSITION)
    begin
      r = stcs_pkg::REG_POSITION;
    end
    return r;
  endfunction

  // assemble the 40 configurable status positions
  function automatic logic [39:0] build_vec
  (
    input logic [7:0] fmt,
    input logic [7:0] cat,
    input logic [7:0] sc,
    input logic [7:0] ra,
    input logic [7:0] wl
  );
    logic [39:0] v;
    v        = '0;
    v[0]     = fmt[0];     // R7
    v[1]     = fmt[1];     // R8
    v[2]     = fmt[2];     // R9
    v[5:3]   = fmt[5:3];   // R10
    v[7:6]   = fmt[7:6];   // R11
    v[15:8]  = cat;        // R12
    v[19:16] = sc[3:0];    // R18
    v[21:20] = sc[5:4];    // R13
    v[23:22] = sc[7:6];    // R14
    v[27:24] = ra[3:0];    // R15
    v[29:28] = ra[5:4];    // R16
    v[32]    = wl[0];      // R17
    v[35:33] = wl[3:1];    // R17
    v[39:36] = wl[7:4];    // R18
    return v;
  endfunction

  assign sel_reg  = decode(paddr);
  assign wr_en    = psel & penable & pwrite & pstrb[0];
  assign rd_setup = psel & ~penable;

  // one write strobe per register; the position register has none
  assign wr_format   = wr_en & (sel_reg == stcs_pkg::REG_FORMAT);
  assign wr_category = wr_en & (sel_reg == stcs_pkg::REG_CATEGORY);
  assign wr_src_chan = wr_en & (sel_reg == stcs_pkg::REG_SRC_CHAN);
  assign wr_rate_acc = wr_en & (sel_reg == stcs_pkg::REG_RATE_ACC);
  assign wr_word_len = wr_en & (sel_reg == stcs_pkg::REG_WORD_LEN);

  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (sel_reg == stcs_pkg::REG_NONE);
  assign prdata  = rdata_r;

  assign data_source_sel   = rate_acc_r[stcs_pkg::POS_DATA_SOURCE];
  assign status_origin_sel = rate_acc_r[stcs_pkg::POS_STATUS_ORIGIN];

  assign relay    = ~data_source_sel & ~status_origin_sel; // R4 R5 R22
  assign live_vec = build_vec(format_r, category_r, src_chan_r, rate_acc_r, word_len_r);

  // at a block start the freshly latched content is used in the same frame
  assign cur_vec   = sf_block_start ? live_vec : shadow_r; // R20
  assign cur_frame = sf_block_start ? stcs_pkg::FIRST_FRAME : frame_r; // R19

  // status bit for the requested sub-frame
  always_comb
  begin
    status_now = 1'b0;
    if (relay)
    begin
      status_now = rx_status_bit; // R4
    end
    else if (cur_frame < 8'(stcs_pkg::CFG_BITS))
    begin
      status_now = cur_vec[cur_frame[5:0]]; // R2 R19
    end
  end

  // format register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      format_r <= stcs_pkg::RST_FORMAT;
    end
    else if (wr_format)
    begin
      format_r <= pwdata[7:0]; // R10 R11
    end
  end

  // category register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      category_r <= stcs_pkg::RST_CATEGORY;
    end
    else if (wr_category)
    begin
      category_r <= pwdata[7:0];
    end
  end

  // source and channel register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_chan_r <= stcs_pkg::RST_SRC_CHAN;
    end
    else if (wr_src_chan)
    begin
      src_chan_r <= pwdata[7:0];
    end
  end

  // rate, accuracy and source select register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rate_acc_r <= stcs_pkg::RST_RATE_ACC; // R21 R22
    end
    else if (wr_rate_acc)
    begin
      rate_acc_r <= pwdata[7:0];
    end
  end

  // word length register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      word_len_r <= stcs_pkg::RST_WORD_LEN;
    end
    else if (wr_word_len)
    begin
      word_len_r <= pwdata[7:0];
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_r <= 32'h0000_0000;
    end
    else if (rd_setup)
    begin
      if (sel_reg == stcs_pkg::REG_FORMAT)
      begin
        rdata_r <= {24'h00_0000, format_r};
      end
      else if (sel_reg == stcs_pkg::REG_CATEGORY)
      begin
        rdata_r <= {24'h00_0000, category_r};
      end
      else if (sel_reg == stcs_pkg::REG_SRC_CHAN)
      begin
        rdata_r <= {24'h00_0000, src_chan_r};
      end
      else if (sel_reg == stcs_pkg::REG_RATE_ACC)
      begin
        rdata_r <= {24'h00_0000, rate_acc_r};
      end
      else if (sel_reg == stcs_pkg::REG_WORD_LEN)
      begin
        rdata_r <= {24'h00_0000, word_len_r};
      end
      else if (sel_reg == stcs_pkg::REG_POSITION)
      begin
        rdata_r <= {23'h00_0000, relay, frame_r};
      end
      else
      begin
        rdata_r <= 32'h0000_0000;
      end
    end
  end

  // frame position within the block; advances after the second sub-frame
  always_comb
  begin
    frame_nxt = frame_r;
    if (sf_req)
    begin
      if (!sf_second)
      begin
        frame_nxt = cur_frame;
      end
      else if (cur_frame == stcs_pkg::LAST_FRAME)
      begin
        frame_nxt = stcs_pkg::FIRST_FRAME; // R1
      end
      else
      begin
        frame_nxt = cur_frame + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_r <= stcs_pkg::FIRST_FRAME;
    end
    else
    begin
      frame_r <= frame_nxt;
    end
  end

  // block content frozen at the boundary
  always_comb
  begin
    shadow_nxt = shadow_r;
    if (sf_req & ~sf_second & sf_block_start)
    begin
      shadow_nxt = live_vec; // R20
    end
    else if (sf_req & sf_second & ~sf_block_start & (frame_r == stcs_pkg::LAST_FRAME))
    begin
      shadow_nxt = live_vec; // R20
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shadow_r <= build_vec(stcs_pkg::RST_FORMAT, stcs_pkg::RST_CATEGORY,
                            stcs_pkg::RST_SRC_CHAN, stcs_pkg::RST_RATE_ACC,
                            stcs_pkg::RST_WORD_LEN);
    end
    else
    begin
      shadow_r <= shadow_nxt;
    end
  end

  // answer strobe one cycle after each request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cs_valid_r <= 1'b0;
    end
    else
    begin
      cs_valid_r <= sf_req;
    end
  end

  // status bit; both sub-frames read the same vector
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cs_bit_r <= 1'b0;
    end
    else if (sf_req)
    begin
      cs_bit_r <= status_now; // R1 R3
    end
  end

  // even parity over payload, validity, user and status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      parity_r <= 1'b0;
    end
    else if (sf_req)
    begin
      parity_r <= ^{sf_audio, sf_validity, sf_user, status_now}; // R6
    end
  end

  assign cs_valid   = cs_valid_r;
  assign cs_bit     = cs_bit_r;
  assign parity_bit = parity_r;

endmodule

// *** bench/stcs_tx_status_assertions.sv ***
`timescale 1ns/10ps
module stcs_chk
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pslverr,
  input wire logic        sf_req,
  input wire logic [23:0] sf_audio,
  input wire logic        sf_validity,
  input wire logic        sf_user,
  input wire logic        rx_status_bit,
  input wire logic        cs_valid,
  input wire logic        cs_bit,
  input wire logic        parity_bit,
  input wire logic        data_source_sel,
  input wire logic        status_origin_sel
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_answer_next: assert property (sf_req |=> cs_valid)
    else $error("no status answer");
  a_answer_cause: assert property (cs_valid |-> $past(sf_req))
    else $error("stray status answer");
  a_bit_holds: assert property (!cs_valid |-> $stable(cs_bit) && $stable(parity_bit))
    else $error("status bit moved");
  a_parity_even: assert property (sf_req |=> parity_bit ==
    ^{$past(sf_audio), $past(sf_validity), $past(sf_user), cs_bit}) else $error("odd parity");
  a_relay_copy: assert property (sf_req && !data_source_sel && !status_origin_sel
    |=> cs_bit == $past(rx_status_bit)) else $error("relay bit wrong");
  a_src_write: assert property ($changed(data_source_sel) |->
    $past(psel && penable && pwrite)) else $error("source select moved");
  a_origin_write: assert property ($changed(status_origin_sel) |->
    $past(psel && penable && pwrite)) else $error("origin select moved");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
endmodule

bind stcs_tx_status stcs_chk u_chk (.*);

// *** bench/stcs_rx_model.sv ***
`timescale 1ns/10ps
module stcs_rx_model
(
  input wire logic         clk,
  input wire logic         req,
  input wire logic         sec,
  input wire logic         bstart,
  input wire logic [25:0]  pay,
  input wire logic         vld,
  input wire logic         bit_in,
  input wire logic         par,
  output logic     [191:0] got_a,
  output logic     [191:0] got_b,
  output int               par_err
);
  logic        sec_r;
  logic [25:0] pay_r;
  int          idx_r = 0;
  int          err_r = 0;
  assign par_err = err_r;
  always @(posedge clk)
  begin
    if (req)
    begin
      sec_r <= sec;
      pay_r <= pay;
    end
    if (vld)
    begin
      if (sec_r)
        got_b[idx_r] <= bit_in;
      else
        got_a[idx_r] <= bit_in;
      if (par !== ^{pay_r, bit_in})
        err_r <= err_r + 1;
      if (sec_r)
        idx_r <= (idx_r == 191) ? 0 : idx_r + 1;
    end
    if (req && bstart)
      idx_r <= 0;
  end
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0]  paddr = '0;
  logic [31:0]  pwdata = '0, prdata, rd;
  logic [3:0]   pstrb = '0;
  logic         pready, pslverr, cs_valid, cs_bit, parity_bit, data_source_sel;
  logic         status_origin_sel, sf_req = 0, sf_second = 0, sf_block_start = 0;
  logic         sf_validity = 0, sf_user = 0, rx_status_bit = 0;
  logic [23:0]  sf_audio = '0;
  logic [191:0] got_a, got_b, rxp = '1;
  int           par_err, bad_count = 0, n_compared = 0;

  stcs_tx_status dut (.*);
  stcs_rx_model peer (.clk(pclk), .req(sf_req), .sec(sf_second), .bstart(sf_block_start),
    .pay({sf_audio, sf_validity, sf_user}), .vld(cs_valid), .bit_in(cs_bit),
    .par(parity_bit), .got_a(got_a), .got_b(got_b), .par_err(par_err));

  always #2 pclk = ~pclk;

  task automatic chk(input string nm, input logic [191:0] e, input logic [191:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic send(input int f0, input int cnt);
    for (int f = f0; f < f0 + cnt; f++)
      for (int s = 0; s < 2; s++)
      begin
        sf_req <= 1'b1;
        sf_second <= s[0];
        sf_block_start <= (f == 0 && s == 0);
        sf_audio <= 24'(f * 24'h9e37 + s);
        {sf_user, sf_validity} <= 2'(f);
        rx_status_bit <= rxp[f];
        @(posedge pclk);
      end
    sf_req <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic t_regs;
    logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h00, 8'h71, 8'h0b};
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, 12'h048 + 12'(4 * i), 8'h00, 4'hf);
      chk("reset value", {24'h0, rv[i]}, rd);
    end
    chk("source select", 1'b1, data_source_sel);
    chk("origin select", 1'b0, status_origin_sel);
    apb(1'b0, 12'h060, 8'h00, 4'hf);
    chk("unmapped error", 1'b1, er);
    $display("register reset test done");
  endtask

  task automatic t_block;
    send(0, 100);
    apb(1'b1, 12'h048, 8'h0e, 4'hf);
    apb(1'b1, 12'h04c, 8'ha5, 4'hf);
    apb(1'b1, 12'h050, 8'h9c, 4'hf);
    apb(1'b1, 12'h054, 8'h6b, 4'hf);
    apb(1'b1, 12'h058, 8'hd4, 4'hf);
    apb(1'b1, 12'h04c, 8'hff, 4'h0);
    send(100, 92);
    chk("old block", 40'h0b_3100_0000, got_a);
    send(0, 192);
    chk("first sub-frame", 40'hd4_2b9c_a50e, got_a);
    chk("second sub-frame", 40'hd4_2b9c_a50e, got_b);
    chk("parity errors", 0, par_err);
    $display("register block test done");
  endtask

  task automatic t_relay;
    rxp = {48{4'h9}};
    apb(1'b1, 12'h054, 8'h31, 4'hf);
    chk("source select", 1'b0, data_source_sel);
    send(0, 192);
    chk("relayed first", rxp, got_a);
    chk("relayed second", rxp, got_b);
    apb(1'b0, 12'h05c, 8'h00, 4'hf);
    chk("position", 32'h0000_0100, rd);
    chk("position error", 1'b0, er);
    apb(1'b1, 12'h054, 8'hb1, 4'hf);
    chk("origin select", 1'b1, status_origin_sel);
    send(0, 192);
    chk("register status", 40'hd4_319c_a50e, got_a);
    $display("relay test done");
  endtask

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_block();
    t_relay();
    finish_test();
  end

  initial
  begin
    #100000;
    bad_count++;
    finish_test();
  end
endmodule
